// file: rsc_defs.svh
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define RSC_CLK_PERIOD_NS 40
`define RSC_CLK_KHZ 25000
`define RSC_POR_DELAY_MS 20
`define RSC_POR_DELAY_CYC (`RSC_POR_DELAY_MS * `RSC_CLK_KHZ)
`define RSC_MR_LOW_MIN_NS 20
`define RSC_MR_LOW_MIN_CYC (((`RSC_MR_LOW_MIN_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS) < 1 ? 1 : \
    ((`RSC_MR_LOW_MIN_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS))

// ----------------------------------------
// reset values and fields
// ----------------------------------------
`define RSC_MR_PIN_RST 1'b1
`define RSC_MS_MAX 3'h4
`define RSC_MS_W 3
`define RSC_STARTUP_W 2
`define RSC_ADDR_STRAP_W 2

`endif

// file: rsc_pkg.sv
package rsc_pkg;

    // sequencer states
    typedef enum logic [3:0] {
        RSC_IDLE,
        RSC_STRAP,
        RSC_LOAD,
        RSC_VCO,
        RSC_APLL,
        RSC_DELAY,
        RSC_DIVSYNC,
        RSC_DPLL
    } rsc_state_t;

    // step reported to the analog and digital helpers
    typedef enum logic [2:0] {
        RSC_STEP_LOAD,
        RSC_STEP_VCO,
        RSC_STEP_APLL,
        RSC_STEP_DELAY,
        RSC_STEP_DIVSYNC,
        RSC_STEP_DPLL
    } rsc_step_t;

endpackage

// file: rsc_sync.sv
`timescale 1ns/1ps
`default_nettype none

module rsc_sync #(
    parameter int W = 1,
    parameter logic RST_VAL = 1'b0
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    initial begin
        if (W < 1) begin
            $error("rsc_sync: W must be at least 1");
        end
    end

    // two-stage synchroniser, first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            meta_q <= {W{RST_VAL}};
            sync_out <= {W{RST_VAL}};
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

`default_nettype wire

// file: rsc_out_drive.sv
`timescale 1ns/1ps
`default_nettype none

module rsc_out_drive #(
    parameter int NOUT = 4
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic [NOUT-1:0] out_en,
    input wire logic [NOUT-1:0] out_is_cmos,
    input wire logic [NOUT-1:0] out_same_phase,
    input wire logic [NOUT-1:0] out_clk_in,
    output logic [NOUT-1:0] out_true,
    output logic [NOUT-1:0] out_comp
);

    initial begin
        if (NOUT < 1) begin
            $error("rsc_out_drive: NOUT must be at least 1");
        end
    end

    // ----------------------------------------
    // per-output drive and disable levels
    // ----------------------------------------
    for (genvar i = 0; i < NOUT; i++) begin : g_out
        // disabled: true low, complement high unless cmos same-phase
        always_ff @(posedge ref_clk) begin
            if (!nrst) begin
                out_true[i] <= 1'b0;
                out_comp[i] <= 1'b1;
            end else if (out_en[i]) begin
                out_true[i] <= out_clk_in[i];
                out_comp[i] <= (out_is_cmos[i] && out_same_phase[i]) ? out_clk_in[i] : ~out_clk_in[i];
            end else begin
                out_true[i] <= 1'b0;
                out_comp[i] <= !(out_is_cmos[i] && out_same_phase[i]);
            end
        end

        property p_disabled_level;
            @(posedge ref_clk) disable iff (!nrst)
            !out_en[i] |=> !out_true[i] && (out_comp[i] == !$past(out_is_cmos[i] && out_same_phase[i]));
        endproperty
        a_disabled_level: assert property (p_disabled_level) else $error("disabled output level wrong");
    end

endmodule

`default_nettype wire

// file: rsc_reset_seq.sv
`timescale 1ns/1ps
`default_nettype none

`include "rsc_defs.svh"

module rsc_reset_seq
    import rsc_pkg::*;
#(
    parameter int unsigned POR_DELAY_CYC = `RSC_POR_DELAY_CYC,
    parameter int NGPIO = 4,
    parameter int NOUT = 4
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic supply_ok_pin,
    input wire logic master_reset_pin,
    input wire logic chip_select_strap_pin,
    input wire logic data_out_strap_pin,
    input wire logic [NGPIO-1:0] gpio_strap_pin,
    input wire logic strap_cfg_en,
    input wire logic strap_addr_en,
    input wire logic relatch_on_soft,
    input wire logic reload_on_soft,
    input wire logic eeprom_present,
    input wire logic soft_reset_wr,
    input wire logic apll_reinit_wr,
    input wire logic [NGPIO-1:0] gpio_ready_sel,
    input wire logic [NOUT*`RSC_STARTUP_W-1:0] out_startup,
    input wire logic [NOUT-1:0] out_is_cmos,
    input wire logic [NOUT-1:0] out_same_phase,
    input wire logic [NOUT-1:0] out_clk_in,
    input wire logic step_done,
    output logic step_go,
    output rsc_step_t step_id,
    output logic eeprom_load_en,
    output logic por_q,
    output logic ready_q,
    output logic serial_port_en,
    output logic soft_reset_bit_q,
    output logic apll_reinit_bit_q,
    output logic irq_status_clr_q,
    output logic seq_busy,
    output logic [NGPIO+1:0] strap_q,
    output logic [NGPIO+1:0] config_strap_q,
    output logic [`RSC_ADDR_STRAP_W-1:0] i2c_addr_strap_q,
    output logic [NGPIO-1:0] gpio_ready_q,
    output logic [NOUT-1:0] out_true,
    output logic [NOUT-1:0] out_comp
);

    localparam int CW = $clog2(POR_DELAY_CYC + 1);

    initial begin
        if (POR_DELAY_CYC < 1 || NGPIO < 1 || NOUT < 1) begin
            $error("rsc_reset_seq: POR_DELAY_CYC, NGPIO and NOUT must be at least 1");
        end
    end

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic supply_s;
    logic mr_s;
    logic [NGPIO+1:0] strap_s;

    rsc_sync #(.W(1), .RST_VAL(1'b0)) u_sync_supply (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .async_in(supply_ok_pin),
        .sync_out(supply_s)
    );

    rsc_sync #(.W(1), .RST_VAL(`RSC_MR_PIN_RST)) u_sync_mr (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .async_in(master_reset_pin),
        .sync_out(mr_s)
    );

    rsc_sync #(.W(NGPIO + 2), .RST_VAL(1'b0)) u_sync_strap (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .async_in({gpio_strap_pin, data_out_strap_pin, chip_select_strap_pin}),
        .sync_out(strap_s)
    );

    // ----------------------------------------
    // power-on reset delay
    // ----------------------------------------
    logic [CW-1:0] por_cnt_q;

    // count the supply-good time, restart on any dropout
    always_ff @(posedge ref_clk) begin
        if (!nrst || !supply_s) begin
            por_cnt_q <= '0;
            por_q <= 1'b0;
        end else if (!por_q) begin
            if (por_cnt_q == CW'(POR_DELAY_CYC - 1)) begin
                por_q <= 1'b1;
            end else begin
                por_cnt_q <= por_cnt_q + CW'(1);
            end
        end
    end

    // ----------------------------------------
    // sequence start requests
    // ----------------------------------------
    logic mr_prev_q;
    logic first_q;
    logic mr_start;
    logic soft_take;
    logic reinit_take;

    // pin edge tracker; a low shorter than one clock may be missed
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            mr_prev_q <= `RSC_MR_PIN_RST;
        end else begin
            mr_prev_q <= mr_s;
        end
    end

    // level starts the first run, a low-high edge each later one
    assign mr_start = por_q && (first_q ? (mr_s && !mr_prev_q) : mr_s);
    assign soft_take = soft_reset_bit_q && ready_q && !mr_start;
    assign reinit_take = apll_reinit_bit_q && ready_q && !mr_start && !soft_reset_bit_q;

    // remember that the first master run has begun
    always_ff @(posedge ref_clk) begin
        if (!nrst || !por_q) begin
            first_q <= 1'b0;
        end else if (mr_start) begin
            first_q <= 1'b1;
        end
    end

    // self-clearing command bits, writable only when ready
    always_ff @(posedge ref_clk) begin
        if (!nrst || !por_q) begin
            soft_reset_bit_q <= 1'b0;
            apll_reinit_bit_q <= 1'b0;
        end else begin
            soft_reset_bit_q <= soft_reset_wr && ready_q;
            apll_reinit_bit_q <= apll_reinit_wr && ready_q;
        end
    end

    // one-cycle clear of interrupt status on soft reset
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            irq_status_clr_q <= 1'b0;
        end else begin
            irq_status_clr_q <= soft_take;
        end
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    rsc_state_t state_q;
    logic issued_q;
    logic soft_q;
    logic reload_q;
    logic step_fin;

    assign step_fin = issued_q && step_done;

    // step walk: strap, load, vco, apll, delay cells, dividers, dpll
    always_ff @(posedge ref_clk) begin
        if (!nrst || !por_q) begin
            state_q <= RSC_IDLE;
            issued_q <= 1'b0;
            soft_q <= 1'b0;
            reload_q <= 1'b0;
        end else if (mr_start) begin
            state_q <= RSC_STRAP;
            issued_q <= 1'b0;
            soft_q <= 1'b0;
            reload_q <= 1'b1;
        end else if (soft_take) begin
            issued_q <= 1'b0;
            soft_q <= 1'b1;
            reload_q <= reload_on_soft;
            if (relatch_on_soft) begin
                state_q <= RSC_STRAP;
            end else if (reload_on_soft) begin
                state_q <= RSC_LOAD;
            end else begin
                state_q <= RSC_VCO;
            end
        end else if (reinit_take) begin
            state_q <= RSC_VCO;
            issued_q <= 1'b0;
            soft_q <= 1'b1;
            reload_q <= 1'b0;
        end else begin
            unique case (state_q)
                RSC_IDLE: begin
                    issued_q <= 1'b0;
                end
                RSC_STRAP: begin
                    state_q <= reload_q ? RSC_LOAD : RSC_VCO;
                end
                RSC_LOAD, RSC_VCO, RSC_APLL, RSC_DELAY, RSC_DIVSYNC, RSC_DPLL: begin
                    if (!issued_q) begin
                        issued_q <= 1'b1;
                    end else if (step_done) begin
                        issued_q <= 1'b0;
                        unique case (state_q)
                            RSC_LOAD: state_q <= RSC_VCO;
                            RSC_VCO: state_q <= RSC_APLL;
                            RSC_APLL: state_q <= RSC_DELAY;
                            RSC_DELAY: state_q <= RSC_DIVSYNC;
                            RSC_DIVSYNC: state_q <= RSC_DPLL;
                            default: state_q <= RSC_IDLE;
                        endcase
                    end
                end
            endcase
        end
    end

    // step request and its code
    assign step_go = (state_q != RSC_IDLE) && (state_q != RSC_STRAP) && !issued_q;
    assign seq_busy = (state_q != RSC_IDLE);
    assign eeprom_load_en = (state_q == RSC_LOAD) && eeprom_present;

    always_comb begin
        unique case (state_q)
            RSC_VCO: step_id = RSC_STEP_VCO;
            RSC_APLL: step_id = RSC_STEP_APLL;
            RSC_DELAY: step_id = RSC_STEP_DELAY;
            RSC_DIVSYNC: step_id = RSC_STEP_DIVSYNC;
            RSC_DPLL: step_id = RSC_STEP_DPLL;
            default: step_id = RSC_STEP_LOAD;
        endcase
    end

    // ----------------------------------------
    // ready flag and strap capture
    // ----------------------------------------
    // ready clears on master start or reloading soft reset, sets after load
    always_ff @(posedge ref_clk) begin
        if (!nrst || !por_q) begin
            ready_q <= 1'b0;
        end else if (mr_start) begin
            ready_q <= 1'b0;
        end else if (soft_take && reload_on_soft) begin
            ready_q <= 1'b0;
        end else if (state_q == RSC_LOAD && step_fin) begin
            ready_q <= 1'b1;
        end
    end

    assign serial_port_en = ready_q;

    // straps sampled in the strap step; decoded copies follow the enables
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            strap_q <= '0;
        end else if (state_q == RSC_STRAP) begin
            strap_q <= strap_s;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            config_strap_q <= '0;
            i2c_addr_strap_q <= '0;
        end else begin
            config_strap_q <= strap_cfg_en ? strap_q : '0;
            i2c_addr_strap_q <= strap_addr_en ? strap_q[1:0] : '0;
        end
    end

    // ready flag mirrored on selected gpios
    for (genvar g = 0; g < NGPIO; g++) begin : g_gpio
        always_ff @(posedge ref_clk) begin
            if (!nrst) begin
                gpio_ready_q[g] <= 1'b0;
            end else begin
                gpio_ready_q[g] <= gpio_ready_sel[g] && ready_q;
            end
        end
    end

    // ----------------------------------------
    // output startup milestones
    // ----------------------------------------
    logic [`RSC_MS_W-1:0] ms_q;
    logic [NOUT-1:0] out_en;
    logic ms_evt;

    // milestones: load, apll lock, divider sync, dpll start
    assign ms_evt = step_fin && !soft_q &&
        (state_q == RSC_LOAD || state_q == RSC_APLL || state_q == RSC_DIVSYNC || state_q == RSC_DPLL);

    always_ff @(posedge ref_clk) begin
        if (!nrst || !por_q || mr_start) begin
            ms_q <= '0;
        end else if (ms_evt && ms_q != `RSC_MS_MAX) begin
            ms_q <= ms_q + `RSC_MS_W'(1);
        end
    end

    for (genvar o = 0; o < NOUT; o++) begin : g_en
        assign out_en[o] = ms_q > `RSC_MS_W'(out_startup[o*`RSC_STARTUP_W +: `RSC_STARTUP_W]);
    end

    rsc_out_drive #(.NOUT(NOUT)) u_out (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .out_en(out_en),
        .out_is_cmos(out_is_cmos),
        .out_same_phase(out_same_phase),
        .out_clk_in(out_clk_in),
        .out_true(out_true),
        .out_comp(out_comp)
    );

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_por_delay;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(por_q) |-> $past(por_cnt_q) == CW'(POR_DELAY_CYC - 1) && supply_s;
    endproperty
    a_por_delay: assert property (p_por_delay) else $error("por rose at wrong count");

    property p_first_start;
        @(posedge ref_clk) disable iff (!nrst)
        por_q && !first_q && mr_s |=> state_q == RSC_STRAP && first_q;
    endproperty
    a_first_start: assert property (p_first_start) else $error("first master run not started");

    property p_edge_start;
        @(posedge ref_clk) disable iff (!nrst)
        por_q && first_q && !mr_prev_q && mr_s |=> state_q == RSC_STRAP && !ready_q;
    endproperty
    a_edge_start: assert property (p_edge_start) else $error("pin edge did not restart");

    property p_hold_low;
        @(posedge ref_clk) disable iff (!nrst)
        por_q && !first_q && !mr_s |=> !first_q;
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("master run began with pin low");

    property p_out_off;
        @(posedge ref_clk) disable iff (!nrst)
        mr_start |=> ms_q == '0 ##1 out_true == '0;
    endproperty
    a_out_off: assert property (p_out_off) else $error("outputs not disabled at master start");

    property p_order;
        @(posedge ref_clk) disable iff (!nrst || mr_start || soft_take || reinit_take)
        state_q == RSC_APLL && step_fin |=> state_q == RSC_DELAY && step_go && step_id == RSC_STEP_DELAY;
    endproperty
    a_order: assert property (p_order) else $error("step order broken");

    property p_port_gate;
        @(posedge ref_clk) disable iff (!nrst)
        (serial_port_en == ready_q) && (!soft_reset_bit_q || $past(ready_q));
    endproperty
    a_port_gate: assert property (p_port_gate) else $error("port enable differs from ready");

    property p_soft_clear;
        @(posedge ref_clk) disable iff (!nrst || mr_start)
        soft_take |=> irq_status_clr_q && !soft_reset_bit_q;
    endproperty
    a_soft_clear: assert property (p_soft_clear) else $error("soft reset did not clear status");

    property p_no_relatch;
        @(posedge ref_clk) disable iff (!nrst || mr_start)
        soft_take && !relatch_on_soft |=> state_q != RSC_STRAP ##1 $stable(strap_q);
    endproperty
    a_no_relatch: assert property (p_no_relatch) else $error("straps resampled without relatch");

    property p_reload;
        @(posedge ref_clk) disable iff (!nrst || mr_start)
        soft_take && reload_on_soft && !relatch_on_soft |=> !ready_q && state_q == RSC_LOAD;
    endproperty
    a_reload: assert property (p_reload) else $error("reload soft reset wrong");

    property p_reinit;
        @(posedge ref_clk) disable iff (!nrst || mr_start)
        reinit_take |=> state_q == RSC_VCO && ready_q && !irq_status_clr_q;
    endproperty
    a_reinit: assert property (p_reinit) else $error("loop restart wrong");

    property p_ready_load;
        @(posedge ref_clk) disable iff (!nrst)
        $rose(ready_q) |-> $past(state_q) == RSC_LOAD && $past(step_fin);
    endproperty
    a_ready_load: assert property (p_ready_load) else $error("ready set outside load");

    property p_gpio_mirror;
        @(posedge ref_clk) disable iff (!nrst)
        gpio_ready_sel[0] && ready_q |=> gpio_ready_q[0];
    endproperty
    a_gpio_mirror: assert property (p_gpio_mirror) else $error("gpio does not mirror ready");

    c_master_done: cover property (@(posedge ref_clk) disable iff (!nrst)
        state_q == RSC_DPLL && step_fin && !soft_q);
    c_soft_reload: cover property (@(posedge ref_clk) disable iff (!nrst) soft_take && reload_on_soft);
    c_reinit: cover property (@(posedge ref_clk) disable iff (!nrst) reinit_take);
    c_restart: cover property (@(posedge ref_clk) disable iff (!nrst) mr_start && first_q);

endmodule

`default_nettype wire

// file: rsc_step_model.sv
`timescale 1ns/1ps
`default_nettype none

module rsc_step_model
    import rsc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic step_go,
    input wire rsc_step_t step_id,
    input wire logic eeprom_load_en,
    input wire logic [3:0] dly,
    output logic step_done,
    output logic [17:0] hist_q,
    output logic ee_seen_q
);
    int cnt_q;

    // ----------------------------------------
    // step helper
    // ----------------------------------------
    // logs each started step, finishes it dly cycles later with a pulse
    always_ff @(posedge ref_clk) begin
        step_done <= 1'b0;
        if (!nrst) begin
            cnt_q <= 0;
            hist_q <= 18'h0_0000;
            ee_seen_q <= 1'b0;
        end else if (step_go) begin
            cnt_q <= int'(dly);
            hist_q <= {hist_q[14:0], step_id};
            if (step_id == RSC_STEP_LOAD) begin
                ee_seen_q <= eeprom_load_en; // load pulls from eeprom when present
            end
        end else if (cnt_q == 1) begin
            cnt_q <= 0;
            step_done <= 1'b1;
        end else if (cnt_q > 1) begin
            cnt_q <= cnt_q - 1;
        end
    end
endmodule

`default_nettype wire

// file: reset_sequence_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none

module reset_sequence_controller_tb
    import rsc_pkg::*;
;
    localparam logic [17:0] FULL = {RSC_STEP_LOAD, RSC_STEP_VCO, RSC_STEP_APLL, RSC_STEP_DELAY,
        RSC_STEP_DIVSYNC, RSC_STEP_DPLL};
    logic ref_clk, nrst, supply_ok_pin, master_reset_pin, chip_select_strap_pin, data_out_strap_pin;
    logic strap_cfg_en, strap_addr_en, relatch_on_soft, reload_on_soft, eeprom_present;
    logic soft_reset_wr, apll_reinit_wr, step_done, step_go, eeprom_load_en, por_q, ready_q;
    logic serial_port_en, soft_reset_bit_q, apll_reinit_bit_q, irq_status_clr_q, seq_busy, ee_seen_q;
    logic [3:0] gpio_strap_pin, gpio_ready_sel, out_is_cmos, out_same_phase, out_clk_in, gpio_ready_q;
    logic [3:0] out_true, out_comp, dly;
    logic [7:0] out_startup;
    logic [5:0] strap_q, config_strap_q;
    logic [1:0] i2c_addr_strap_q;
    logic [17:0] hist_q;
    rsc_step_t step_id;
    int errors, cmp_count;
    bit clr_seen, rdy_low, bit_seen;

    rsc_reset_seq #(.POR_DELAY_CYC(20), .NGPIO(4), .NOUT(4)) rsc_reset_seq_i (.ref_clk, .nrst,
        .supply_ok_pin, .master_reset_pin, .chip_select_strap_pin, .data_out_strap_pin, .gpio_strap_pin,
        .strap_cfg_en, .strap_addr_en, .relatch_on_soft, .reload_on_soft, .eeprom_present, .soft_reset_wr,
        .apll_reinit_wr, .gpio_ready_sel, .out_startup, .out_is_cmos, .out_same_phase, .out_clk_in,
        .step_done, .step_go, .step_id, .eeprom_load_en, .por_q, .ready_q, .serial_port_en,
        .soft_reset_bit_q, .apll_reinit_bit_q, .irq_status_clr_q, .seq_busy, .strap_q, .config_strap_q,
        .i2c_addr_strap_q, .gpio_ready_q, .out_true, .out_comp);

    rsc_step_model rsc_step_model_i (.ref_clk, .nrst, .step_go, .step_id, .eeprom_load_en, .dly,
        .step_done, .hist_q, .ee_seen_q);

    // clock at 25 MHz
    always #20 ref_clk = ~ref_clk;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // step past the edge, then note pulses and ready drops
    task automatic tick();
        @(posedge ref_clk);
        #2;
        if (irq_status_clr_q === 1'b1) clr_seen = 1;
        if (ready_q !== 1'b1) rdy_low = 1;
        if (soft_reset_bit_q === 1'b1 || apll_reinit_bit_q === 1'b1) bit_seen = 1;
    endtask

    // optional write pulse, then wait for the sequence to start and finish
    task automatic run_seq(input bit mr, input bit sw, input bit aw);
        int n;
        clr_seen = 0;
        rdy_low = 0;
        bit_seen = 0;
        soft_reset_wr = sw;
        apll_reinit_wr = aw;
        tick();
        soft_reset_wr = 0;
        apll_reinit_wr = 0;
        n = 0;
        while (seq_busy !== 1'b1 && n < 20) begin
            tick();
            n++;
        end
        if (n >= 20) begin
            errors++;
            report_and_stop();
        end
        if (mr) begin
            repeat (2) tick();
            chk(out_true, 4'h0);
            chk(out_comp, 4'h7);
        end
        while (seq_busy !== 1'b0 && n < 400) begin
            tick();
            n++;
        end
        if (n >= 400) begin
            errors++;
            report_and_stop();
        end
        tick();
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_por();
        int n;
        n = 0;
        while (por_q !== 1'b1 && n < 100) begin
            tick();
            n++;
        end
        chk(n >= 20 && n <= 26, 1);
        repeat (8) tick();
        chk(seq_busy, 0);
        chk(ready_q, 0);
        chk(serial_port_en, 0);
        master_reset_pin = 1;
        run_seq(1, 0, 0);
        chk(hist_q, FULL);
        chk(serial_port_en, 1);
        chk(strap_q, 6'h29);
        chk(config_strap_q, 6'h29);
        chk(i2c_addr_strap_q, 2'h1);
        chk(gpio_ready_q, 4'h5);
        chk(out_true, 4'hf);
        chk(out_comp, 4'h8);
        chk(ee_seen_q, 1);
        $display("test por done");
    endtask

    // pin low for two cycles, above the minimum, held high to ready
    // same restart a host issues after late output supplies
    task automatic t_mr();
        master_reset_pin = 0;
        repeat (2) tick();
        master_reset_pin = 1;
        run_seq(1, 0, 0);
        chk(rdy_low, 1);
        chk(hist_q, FULL);
        $display("test master restart done");
    endtask

    task automatic t_soft(input bit relatch, input bit reload, input logic [5:0] st, input logic [5:0] exp_st);
        relatch_on_soft = relatch;
        reload_on_soft = reload;
        {gpio_strap_pin, data_out_strap_pin, chip_select_strap_pin} = st;
        repeat (4) tick();
        run_seq(0, 1, 0);
        chk(bit_seen, 1);
        chk(soft_reset_bit_q, 0);
        chk(clr_seen, 1);
        chk(strap_q, exp_st);
        chk(rdy_low, reload);
        chk(ready_q, 1);
        chk(hist_q[14:0], FULL[14:0]);
        $display("test soft reset done");
    endtask

    task automatic t_reinit();
        dly = 4'h1;
        run_seq(0, 0, 1);
        chk(bit_seen, 1);
        chk(clr_seen, 0);
        chk(rdy_low, 0);
        chk(hist_q[14:0], FULL[14:0]);
        $display("test loop restart done");
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        ref_clk = 0;
        nrst = 0;
        supply_ok_pin = 1;
        master_reset_pin = 0;
        {gpio_strap_pin, data_out_strap_pin, chip_select_strap_pin} = 6'h29;
        strap_cfg_en = 1;
        strap_addr_en = 1;
        relatch_on_soft = 0;
        reload_on_soft = 0;
        eeprom_present = 1;
        soft_reset_wr = 0;
        apll_reinit_wr = 0;
        gpio_ready_sel = 4'h5;
        out_startup = 8'he4;
        out_is_cmos = 4'hc;
        out_same_phase = 4'ha;
        out_clk_in = 4'hf;
        dly = 4'h3;
        errors = 0;
        cmp_count = 0;
        repeat (10) tick();
        nrst = 1;
        t_por();
        t_mr();
        t_soft(1, 1, 6'h16, 6'h16);
        t_soft(0, 0, 6'h29, 6'h16);
        t_soft(0, 1, 6'h29, 6'h16);
        t_reinit();
        report_and_stop();
    end
endmodule

`default_nettype wire
